// File: core/cssq_consts.vh
// Purpose: constants for the config set sequencer
// Assumes: APB byte addresses, 32-bit data, 10 MHz clk
// Notes: every offset, control and command field lives here, with the word, total and repeat reset values
//
// Summary of operation
// - stored sets are addressed by a set number starting at zero
// - stored sets live in volatile storage and are cleared by reset
// - stored sets are never part of any saved user configuration
// - a set affects acquisition only once copied into the active configuration
// - while running, current set changes only at frame triggers, even on software commands
// - automatic mode climbs through sets with repeats and wraps to zero
// - controlled mode advances from always, input line or software only
// - free selection takes the set number straight from the input line
// - cycling may be modified at any point of a cycle
// - restart begins a new cycle early, from the line or software
// - software skip jumps over the next set to the one after
// - input line is looked at only together with a frame trigger
// - software advance and restart are accepted at any time while running
// - with tagging on, each frame carries the number of its set
// - load command copies the pointed set into the active configuration while stopped
// - while enabled, active values read back as before enabling, writes blocked
// - in automatic mode and with the always source, each set is used its repeat count of frames, 1 to 256
// - cycle length is programmable up to 64 sets
// - enabling loads set 0 into the active configuration
// - disabling waits for the frame to end then restores old values
`ifndef CSSQ_CONSTS_VH
`define CSSQ_CONSTS_VH

`define CSSQ_ADDR_CTRL 8'h00
`define CSSQ_ADDR_TOTAL 8'h04
`define CSSQ_ADDR_POINTER 8'h08
`define CSSQ_ADDR_REPEAT 8'h0C
`define CSSQ_ADDR_SETDATA 8'h10
`define CSSQ_ADDR_ACTIVE 8'h14
`define CSSQ_ADDR_CMD 8'h18
`define CSSQ_ADDR_STATUS 8'h1C

// control register fields
`define CSSQ_CTRL_ON 0
`define CSSQ_CTRL_MODE_LO 1
`define CSSQ_CTRL_MODE_HI 2
`define CSSQ_CTRL_SRC_LO 3
`define CSSQ_CTRL_SRC_HI 4
`define CSSQ_CTRL_TAG 5

// command register bits, write one to request
`define CSSQ_CMD_LOAD 0
`define CSSQ_CMD_ADVANCE 1
`define CSSQ_CMD_SKIP 2
`define CSSQ_CMD_RESTART 3

// advance modes and control sources
`define CSSQ_MODE_AUTO 2'h0
`define CSSQ_MODE_CTRL 2'h1
`define CSSQ_MODE_FREE 2'h2
`define CSSQ_SRC_ALWAYS 2'h0
`define CSSQ_SRC_LINE 2'h1
`define CSSQ_SRC_OFF 2'h2

// sizes and reset values
`define CSSQ_NUM_SETS 64
`define CSSQ_SET_MAX 7'h40
`define CSSQ_TOTAL_RST 7'h01
`define CSSQ_REPEAT_RST 8'h00
`define CSSQ_WORD_RST 32'h00000000
`endif

// File: core/cssq_sequencer.v
// Purpose: config set sequencer with APB register access
// Assumes: frame_trigger is a one-cycle pulse; frame_busy high while a frame is exposed or sent
// Notes: repeat register holds count minus one, so 8'h00 means one use and 8'hFF means 256
`include "cssq_consts.vh"

module cssq_sequencer (
  input wire clk,
  input wire srst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire frame_trigger,
  input wire frame_busy,
  input wire [5:0] line_state,
  output reg [31:0] active_config,
  output reg [5:0] current_set,
  output reg sequencer_running,
  output reg frame_tag_valid,
  output reg [5:0] frame_tag_set
);

  // stored sets: sequenced parameter word and repeat count
  reg [31:0] set_word [0:`CSSQ_NUM_SETS-1];
  reg [7:0] repeat_count_per_set [0:`CSSQ_NUM_SETS-1];

  reg sequencer_on;
  reg [1:0] adv_mode;
  reg [1:0] ctrl_src;
  reg set_number_frame_tag;
  reg [6:0] set_count_total;
  reg [5:0] stored_set_pointer;
  reg [31:0] saved_config;
  reg [8:0] use_count;
  reg first_frame;
  reg pend_advance;
  reg pend_skip;
  reg pend_restart;
  reg disable_wait;

  wire setup_ph = psel & ~penable;
  wire access_ph = psel & penable;
  wire wr_en = access_ph & pwrite;
  wire cmd_wr = wr_en & (paddr == `CSSQ_ADDR_CMD);
  wire load_stored_set_cmd = cmd_wr & pwdata[`CSSQ_CMD_LOAD];
  wire sw_advance = cmd_wr & pwdata[`CSSQ_CMD_ADVANCE];
  wire sw_skip = cmd_wr & pwdata[`CSSQ_CMD_SKIP];
  wire sw_restart = cmd_wr & pwdata[`CSSQ_CMD_RESTART];
  wire trig_run = frame_trigger & sequencer_running;

  integer i;

  // step a set number forward and fold it back into the cycle
  function [5:0] wrap_step;
    input [5:0] cur;
    input [1:0] step;
    input [6:0] total;
    reg [6:0] sum;
    begin
      sum = {1'b0, cur} + {5'h00, step};
      if (sum >= total) begin
        sum = sum - total;
      end
      if (sum >= total) begin
        sum = 7'h00;
      end
      wrap_step = sum[5:0];
    end
  endfunction

  // address decode for the error answer only; the read mux decodes with its own case
  function mapped;
    input [7:0] a;
    begin
      mapped = (a == `CSSQ_ADDR_CTRL) || (a == `CSSQ_ADDR_TOTAL) || (a == `CSSQ_ADDR_POINTER) ||
               (a == `CSSQ_ADDR_REPEAT) || (a == `CSSQ_ADDR_SETDATA) || (a == `CSSQ_ADDR_ACTIVE) ||
               (a == `CSSQ_ADDR_CMD) || (a == `CSSQ_ADDR_STATUS);
    end
  endfunction

  // slave never stalls; read data is captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = access_ph & ~mapped(paddr);

  // next-set decision for one frame trigger while running
  reg [5:0] next_set;
  reg next_same;
  always @* begin
    next_set = current_set;
    next_same = 1'b1;
    if (pend_restart ||
        (adv_mode == `CSSQ_MODE_CTRL && ctrl_src == `CSSQ_SRC_LINE && line_state[1])) begin
      next_set = 6'h00; // restart begins a fresh cycle
      next_same = 1'b0;
    end else if (adv_mode == `CSSQ_MODE_FREE) begin
      next_same = 1'b0; // set picked by line levels
      if ({1'b0, line_state} < set_count_total) begin
        next_set = line_state;
      end
    end else if (pend_skip) begin
      next_set = wrap_step(current_set, 2'h2, set_count_total);
      next_same = 1'b0;
    end else if (pend_advance) begin
      next_set = wrap_step(current_set, 2'h1, set_count_total);
      next_same = 1'b0;
    end else if (adv_mode == `CSSQ_MODE_CTRL && ctrl_src == `CSSQ_SRC_OFF) begin
      next_set = current_set; // held until software acts
    end else if (adv_mode == `CSSQ_MODE_CTRL && ctrl_src == `CSSQ_SRC_LINE) begin
      if (line_state[0]) begin
        next_set = wrap_step(current_set, 2'h1, set_count_total);
        next_same = 1'b0;
      end
    end else if (use_count > {1'b0, repeat_count_per_set[current_set]}) begin
      next_set = wrap_step(current_set, 2'h1, set_count_total);
      next_same = 1'b0;
    end
  end

  // APB read data, registered at setup so it is stable for the access cycle
  always @(posedge clk) begin
    if (srst) begin
      prdata <= `CSSQ_WORD_RST;
    end else if (setup_ph && !pwrite) begin
      case (paddr)
        `CSSQ_ADDR_CTRL: prdata <= {26'h0000000, set_number_frame_tag, ctrl_src, adv_mode, sequencer_on};
        `CSSQ_ADDR_TOTAL: prdata <= {25'h0000000, set_count_total};
        `CSSQ_ADDR_POINTER: prdata <= {26'h0000000, stored_set_pointer};
        `CSSQ_ADDR_REPEAT: prdata <= {24'h000000, repeat_count_per_set[stored_set_pointer]};
        `CSSQ_ADDR_SETDATA: prdata <= set_word[stored_set_pointer];
        // running: shows the values from before enabling
        `CSSQ_ADDR_ACTIVE: prdata <= sequencer_running ? saved_config : active_config;
        `CSSQ_ADDR_STATUS: prdata <= {11'h000, use_count, disable_wait, pend_restart, pend_skip,
                                      pend_advance, sequencer_running, 1'b0, current_set};
        default: prdata <= `CSSQ_WORD_RST;
      endcase
    end
  end

  // control and set storage written by software
  // sets exist only here and nothing exports them for saving
  always @(posedge clk) begin
    if (srst) begin
      sequencer_on <= 1'b0;
      adv_mode <= `CSSQ_MODE_AUTO;
      ctrl_src <= `CSSQ_SRC_ALWAYS;
      set_number_frame_tag <= 1'b0;
      set_count_total <= `CSSQ_TOTAL_RST;
      stored_set_pointer <= 6'h00;
      for (i = 0; i < `CSSQ_NUM_SETS; i = i + 1) begin
        set_word[i] <= `CSSQ_WORD_RST; // volatile: reset wipes every set
        repeat_count_per_set[i] <= `CSSQ_REPEAT_RST;
      end
    end else if (wr_en) begin
      case (paddr)
        `CSSQ_ADDR_CTRL: begin
          sequencer_on <= pwdata[`CSSQ_CTRL_ON];
          adv_mode <= pwdata[`CSSQ_CTRL_MODE_HI:`CSSQ_CTRL_MODE_LO];
          ctrl_src <= pwdata[`CSSQ_CTRL_SRC_HI:`CSSQ_CTRL_SRC_LO];
          set_number_frame_tag <= pwdata[`CSSQ_CTRL_TAG];
        end
        `CSSQ_ADDR_TOTAL: begin
          // out-of-range totals clamp so the cycle stays within 1..64
          if (pwdata[6:0] == 7'h00) begin
            set_count_total <= `CSSQ_TOTAL_RST;
          end else if (pwdata[31:7] != 25'h0000000 || pwdata[6:0] > `CSSQ_SET_MAX) begin
            set_count_total <= `CSSQ_SET_MAX;
          end else begin
            set_count_total <= pwdata[6:0];
          end
        end
        `CSSQ_ADDR_POINTER: stored_set_pointer <= pwdata[5:0];
        `CSSQ_ADDR_REPEAT: repeat_count_per_set[stored_set_pointer] <= pwdata[7:0];
        `CSSQ_ADDR_SETDATA: set_word[stored_set_pointer] <= pwdata;
        default: ;
      endcase
    end
  end

  // pending software commands: a new request wins over the clearing trigger
  always @(posedge clk) begin
    if (srst || !sequencer_running) begin
      pend_advance <= 1'b0;
      pend_skip <= 1'b0;
      pend_restart <= 1'b0;
    end else begin
      pend_advance <= (pend_advance & ~trig_run) | sw_advance;
      pend_skip <= (pend_skip & ~trig_run) | sw_skip;
      pend_restart <= (pend_restart & ~trig_run) | sw_restart;
    end
  end

  // run state, active configuration and frame tagging
  always @(posedge clk) begin
    if (srst) begin
      sequencer_running <= 1'b0;
      disable_wait <= 1'b0;
      first_frame <= 1'b0;
      active_config <= `CSSQ_WORD_RST;
      saved_config <= `CSSQ_WORD_RST;
      current_set <= 6'h00;
      use_count <= 9'h000;
      frame_tag_valid <= 1'b0;
      frame_tag_set <= 6'h00;
    end else begin
      frame_tag_valid <= 1'b0;
      if (!sequencer_running) begin
        if (sequencer_on) begin
          // start: keep old values, copy set 0 in
          sequencer_running <= 1'b1;
          saved_config <= active_config;
          active_config <= set_word[0];
          current_set <= 6'h00;
          use_count <= 9'h000;
          first_frame <= 1'b1;
        end else if (load_stored_set_cmd) begin
          active_config <= set_word[stored_set_pointer];
          current_set <= stored_set_pointer;
        end else if (wr_en && paddr == `CSSQ_ADDR_ACTIVE) begin
          active_config <= pwdata; // direct edits only while stopped
        end
      end else if (!sequencer_on || disable_wait) begin
        // stop only between frames so the frame in flight completes
        if (frame_busy || frame_trigger) begin
          disable_wait <= 1'b1;
        end else begin
          disable_wait <= 1'b0;
          sequencer_running <= 1'b0;
          active_config <= saved_config;
        end
      end else if (frame_trigger) begin
        // set changes happen only on a trigger
        if (first_frame) begin
          first_frame <= 1'b0;
          use_count <= 9'h001;
          frame_tag_set <= current_set;
        end else begin
          current_set <= next_set;
          active_config <= set_word[next_set];
          use_count <= next_same ? use_count + 9'h001 : 9'h001;
          frame_tag_set <= next_set;
        end
        frame_tag_valid <= set_number_frame_tag;
      end
    end
  end

endmodule

// File: sim/cssq_sequencer_properties.sv
// Purpose: temporal checks on the sequencer ports
// Assumes: bound into every cssq_sequencer instance
// Notes: outputs are tied to the trigger or register write that causes them
`include "cssq_consts.vh"
module cssq_props (
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic frame_trigger,
  input wire logic frame_busy,
  input wire logic [5:0] line_state,
  input wire logic [31:0] active_config,
  input wire logic [5:0] current_set,
  input wire logic sequencer_running,
  input wire logic frame_tag_valid,
  input wire logic [5:0] frame_tag_set
);
  timeunit 1ns;
  timeprecision 1ns;
  logic on_wr;
  logic on_wr_d;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // enabling writes are kept two edges, since turn-on may lag the access by one
  always @(posedge clk) begin
    on_wr <= psel & penable & pwrite & (paddr == `CSSQ_ADDR_CTRL) & pwdata[`CSSQ_CTRL_ON];
    on_wr_d <= on_wr;
  end
  chk_tag_pulse: assert property (frame_tag_valid |=> !frame_tag_valid)
    else $error("tag pulse too long");
  chk_tag_cause: assert property (
    frame_tag_valid |-> $past(frame_trigger) && $past(sequencer_running))
    else $error("tag without a trigger");
  chk_tag_number: assert property (frame_tag_valid |-> frame_tag_set == current_set)
    else $error("tag number");
  chk_set_moves: assert property (
    $changed(current_set) && $past(sequencer_running) && sequencer_running |-> $past(frame_trigger))
    else $error("set moved off trigger");
  chk_word_holds: assert property (
    sequencer_running && $past(sequencer_running) && !$past(frame_trigger) |-> $stable(active_config))
    else $error("active word changed while running");
  chk_start_zero: assert property ($rose(sequencer_running) |-> current_set == 6'h00)
    else $error("start set");
  chk_start_cause: assert property ($rose(sequencer_running) |-> on_wr || on_wr_d)
    else $error("start without enable");
  chk_stop_frame: assert property (
    $fell(sequencer_running) |-> !$past(frame_busy) && !$past(frame_trigger))
    else $error("stopped in a frame");
endmodule
bind cssq_sequencer cssq_props cssq_props_inst (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .frame_trigger, .frame_busy, .line_state, .active_config, .current_set, .sequencer_running,
  .frame_tag_valid, .frame_tag_set);

// File: sim/cssq_frame_src.sv
// Purpose: frame source, one trigger pulse and a busy span starting on the same edge per frame
// Assumes: go rises once per frame request
// Notes: requests during a busy frame are dropped, like a real sensor
module cssq_frame_src #(parameter int BUSY_LEN = 8) (
  input wire logic clk,
  input wire logic srst,
  input wire logic go,
  output logic frame_trigger,
  output logic frame_busy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic go_d;
  logic [3:0] left;
  initial {frame_trigger, frame_busy, go_d, left} = 7'h00;
  // busy covers exposure and readout after the trigger edge
  always @(posedge clk) begin
    go_d <= go;
    frame_trigger <= go & ~go_d & ~frame_busy & ~srst;
    if (srst || left == 4'h1)
      frame_busy <= 1'h0;
    if (srst)
      left <= 4'h0;
    else if (go & ~go_d & ~frame_busy) begin
      left <= BUSY_LEN[3:0];
      frame_busy <= 1'h1;
    end else if (left != 4'h0)
      left <= left - 4'h1;
  end
endmodule

// File: sim/config_set_sequencer_tb.sv
// Purpose: self-checking bench for the config set sequencer
// Assumes: set n holds word 32'hA0 plus n, saved active word is 32'h55
// Notes: sets are edited only while stopped
`include "cssq_consts.vh"
module config_set_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0, srst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, go = 1'h0, tagging = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, active_config, rd;
  logic [5:0] line_state = 6'h00, current_set, frame_tag_set, tag_set, last;
  logic pready, pslverr, frame_trigger, frame_busy, sequencer_running, frame_tag_valid, err, tag_v;
  int fails = 0, samples_checked = 0;
  cssq_sequencer cssq_sequencer_inst (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .frame_trigger, .frame_busy, .line_state, .active_config, .current_set, .sequencer_running,
    .frame_tag_valid, .frame_tag_set);
  cssq_frame_src cssq_frame_src_inst (.clk, .srst, .go, .frame_trigger, .frame_busy);
  initial forever #50 clk = ~clk;
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // the request stands until pready is seen high at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // the tag lives one cycle, so it is caught right after the edge that samples the trigger, one cycle after it rises
  task frame(input logic [5:0] ln);
    @(posedge clk);
    line_state <= ln;
    go <= 1'h1;
    @(posedge clk);
    go <= 1'h0;
    repeat (2) @(negedge clk);
    tag_v = frame_tag_valid;
    tag_set = frame_tag_set;
    while (frame_busy === 1'h1) @(negedge clk);
  endtask
  task mode(input logic [5:0] c);
    apb(1'h1, `CSSQ_ADDR_CTRL, 32'(c));
    repeat (2) @(negedge clk);
    tagging = c[5];
    last = 6'h00;
    chk("running", 32'(sequencer_running), 32'(c[0]));
    if (c[0]) chk("first word", active_config, 32'hA0);
  endtask
  task step(input logic [3:0] cmd, input logic [5:0] ln, input logic [5:0] e);
    if (cmd != 4'h0) begin
      apb(1'h1, `CSSQ_ADDR_CMD, 32'(cmd));
      chk("set before trigger", 32'(current_set), 32'(last));
    end
    frame(ln);
    chk("current set", 32'(current_set), 32'(e));
    chk("active word", active_config, 32'hA0 + 32'(e));
    if (tagging) chk("frame tag", 32'({tag_v, tag_set}), 32'({1'h1, e}));
    last = e;
  endtask
  task t_reset;
    chk("running", 32'(sequencer_running), 32'h0);
    chk("ready", 32'(pready), 32'h1);
    apb(1'h0, `CSSQ_ADDR_TOTAL, 32'h0);
    chk("total", rd, 32'h1);
    apb(1'h1, `CSSQ_ADDR_POINTER, 32'h5);
    apb(1'h0, `CSSQ_ADDR_SETDATA, 32'h0);
    chk("cleared set", rd, 32'h0);
    apb(1'h0, 8'h40, 32'h0);
    chk("unmapped", {err, rd[30:0]}, 32'h80000000);
  endtask
  task t_config;
    apb(1'h1, `CSSQ_ADDR_ACTIVE, 32'h55);
    apb(1'h1, `CSSQ_ADDR_TOTAL, 32'h3);
    for (int i = 0; i < 3; i++) begin
      apb(1'h1, `CSSQ_ADDR_POINTER, i);
      apb(1'h1, `CSSQ_ADDR_SETDATA, 32'hA0 + i);
      apb(1'h1, `CSSQ_ADDR_REPEAT, (i == 1) ? 32'h1 : 32'h0);
    end
    apb(1'h0, `CSSQ_ADDR_SETDATA, 32'h0);
    chk("stored set", rd, 32'hA2);
  endtask
  task t_auto;
    mode(6'h21);
    apb(1'h1, `CSSQ_ADDR_ACTIVE, 32'h77);
    apb(1'h0, `CSSQ_ADDR_ACTIVE, 32'h0);
    chk("hidden active", rd, 32'h55);
    step(4'h0, 6'h00, 6'h00);
    step(4'h0, 6'h00, 6'h01);
    step(4'h0, 6'h00, 6'h01);
    step(4'h0, 6'h00, 6'h02);
    step(4'h0, 6'h00, 6'h00);
    // switch off while a frame is in flight
    @(posedge clk);
    go <= 1'h1;
    apb(1'h1, `CSSQ_ADDR_CTRL, 32'h0);
    go <= 1'h0;
    @(negedge clk);
    chk("running in frame", 32'(sequencer_running), 32'h1);
    while (frame_busy === 1'h1) @(negedge clk);
    repeat (2) @(negedge clk);
    chk("stopped", 32'(sequencer_running), 32'h0);
    chk("restored word", active_config, 32'h55);
  endtask
  task t_soft;
    mode(6'h13);
    step(4'h0, 6'h00, 6'h00);
    step(4'h4, 6'h00, 6'h02);
    step(4'h2, 6'h00, 6'h00);
    step(4'h2, 6'h00, 6'h01);
    step(4'h8, 6'h00, 6'h00);
    // source off: neither repeat count nor line may move the set
    step(4'h0, 6'h01, 6'h00);
    mode(6'h00);
  endtask
  task t_line;
    mode(6'h0B);
    step(4'h0, 6'h00, 6'h00);
    step(4'h0, 6'h01, 6'h01);
    step(4'h0, 6'h02, 6'h00);
    step(4'h0, 6'h01, 6'h01);
    step(4'h0, 6'h01, 6'h02);
    step(4'h0, 6'h01, 6'h00);
    mode(6'h00);
  endtask
  task t_free;
    mode(6'h05);
    @(posedge clk);
    line_state <= 6'h02;
    repeat (3) @(negedge clk);
    chk("no trigger", 32'(current_set), 32'h0);
    // the first frame after enabling always uses set 0
    step(4'h0, 6'h02, 6'h00);
    step(4'h0, 6'h02, 6'h02);
    step(4'h0, 6'h00, 6'h00);
    step(4'h0, 6'h05, 6'h00);
    mode(6'h00);
    apb(1'h1, `CSSQ_ADDR_POINTER, 32'h2);
    apb(1'h1, `CSSQ_ADDR_CMD, 32'h1);
    @(negedge clk);
    chk("loaded word", active_config, 32'hA2);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'h0;
    @(negedge clk);
    t_reset;
    t_config;
    t_auto;
    t_soft;
    t_line;
    t_free;
    conclude;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    conclude;
  end
endmodule
